// ==== common/ccsir_regs.svh ====
// register offsets, field positions and table constants for the context shadow bank
// assumes byte addressing on an APB bus with one 32-bit word per register index
`ifndef CCSIR_REGS_SVH
`define CCSIR_REGS_SVH
`define CCSIR_IDX_STATUS 13'h1FE4
`define CCSIR_IDX_WORKING_REGISTER 13'h1FE5
`define CCSIR_IDX_BANK 13'h1FE6
`define CCSIR_IDX_PCLATCH 13'h1FE7
`define CCSIR_IDX_PTR0_LO 13'h1FE8
`define CCSIR_IDX_PTR0_HI 13'h1FE9
`define CCSIR_IDX_PTR1_LO 13'h1FEA
`define CCSIR_IDX_PTR1_HI 13'h1FEB
`define CCSIR_IDX_EVENT 13'h1FF0
`define CCSIR_IDX_ROM_ADDR 13'h1FF1
`define CCSIR_IDX_ROM_DATA 13'h1FF2
`define CCSIR_BIT_WDT 4
`define CCSIR_BIT_SLEEP 3
`define CCSIR_BIT_ZERO 2
`define CCSIR_BIT_NIB 1
`define CCSIR_BIT_MSB 0
`define CCSIR_STATUS_RW_MASK 8'h07
`define CCSIR_BANK_MASK 8'h3F
`define CCSIR_PCL_MASK 8'h7F
`define CCSIR_EV_POWERUP 0
`define CCSIR_EV_KICK 1
`define CCSIR_EV_SLEEP 2
`define CCSIR_EV_TIMEOUT 3
`define CCSIR_CFG_BASE 16'h8200
`define CCSIR_CFG_LAST 16'h821F
`define CCSIR_INFO_BASE 16'h8100
`define CCSIR_INFO_LAST 16'h811F
`define CCSIR_CFG_ERASE_ROW 14'h0020
`define CCSIR_CFG_LATCHES 14'h0020
`define CCSIR_CFG_USER_ROWS 14'h0200
`define CCSIR_CFG_EEPROM 14'h0100
`define CCSIR_CFG_PINS_IDX 5'h04
`define CCSIR_ROM_WORD_W 14
`define CCSIR_PADDR_MSB 14
`define CCSIR_PADDR_LSB 2
`endif

// ==== common/ccsir_pkg.sv ====
// types shared by the context shadow bank
// assumes nothing beyond the register header
package ccsir_pkg;
  typedef enum logic [1:0] {
    ccsir_alu_none,
    ccsir_alu_add,
    ccsir_alu_sub,
    ccsir_alu_logic
  } ccsir_alu_e;
  typedef logic [7:0] ccsir_byte_t;
endpackage

// ==== src/ccsir_shadow_bank.sv ====
// context shadow bank with status flag logic and two read-only information tables
// assumes an APB master on i_clk_sys and core events as synchronous one-cycle pulses
// Functional notes
// - status shadow at 0x1FE4; bits 4,3 read-only, bits 2..0 writable, 7..5 absent.
// - watchdog expiry flag sets on power-up, kick or sleep; clears on timeout.
// - sleep-entered flag sets on power-up or kick; clears on sleep.
// - zero flag is 1 for a zero arithmetic or logic result, else 0.
// - nibble overflow flag is the carry out of bit 3 for add and subtract.
// - msb overflow flag is the carry out of bit 7 for add and subtract.
// - subtract adds the two's complement, so a clear flag means borrow.
// - rotates through carry load the msb flag from the source's outgoing end bit.
// - shadow registers are not cleared by any reset (power-on value undefined, others keep); the o_status_flags_shadow port resets to 0.
// - working register shadow at 0x1FE5, eight bits read/write.
// - bank select shadow at 0x1FE6, six bits read/write.
// - pc upper latch shadow at 0x1FE7, seven bits read/write.
// - two 16-bit indirect pointer shadows at 0x1FE8 and 0x1FEA.
// - each pointer low and high byte is addressed on its own.
// - configuration region 8200h..821Fh is fixed and read-only.
// - configuration table gives 32, 32, 512, 256 and the pin count.
// - information area 8100h..811Fh is factory fixed and read-only.
`timescale 1ns/10ps
`include "ccsir_regs.svh"
module ccsir_shadow_bank
  import ccsir_pkg::*;
#(
  parameter int ADDR_W = 15,
  parameter logic [13:0] PIN_COUNT = 14'h0014,
  parameter logic [13:0] INFO_FILL = 14'h3FFF
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // core operation results
  input wire logic i_alu_valid,
  input wire ccsir_alu_e i_alu_op,
  input wire logic [7:0] i_alu_a,
  input wire logic [7:0] i_alu_b,
  input wire logic i_rot_valid,
  input wire logic i_rot_left,
  input wire logic [7:0] i_rot_src,
  // shadow state out
  output logic [7:0] o_status_flags_shadow
);
  if (ADDR_W < `CCSIR_PADDR_MSB + 1) begin : g_addr_w_check
    $error("ccsir_shadow_bank: ADDR_W must be at least 15");
  end

  // shadow storage, no reset on purpose
  logic [7:0] status_flags_shadow;
  logic [7:0] working_reg_shadow;
  logic [7:0] bank_select_shadow;
  logic [7:0] pc_upper_latch_shadow;
  logic [15:0] indirect_pointer0_shadow;
  logic [15:0] indirect_pointer1_shadow;
  logic [3:0] event_pulse;
  logic [15:0] rom_addr;
  logic [7:0] next_status;
  logic [7:0] next_working_register;
  logic [7:0] next_bank;
  logic [7:0] next_pcl;
  logic [15:0] next_ptr0;
  logic [15:0] next_ptr1;
  logic [15:0] next_rom_addr;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [8:0] sum;
  logic [4:0] nib_sum;
  logic [7:0] opnd_b;
  logic cin;
  logic [12:0] idx;
  logic wr_en;
  logic rd_en;
  logic ev_kick;
  logic ev_sleep;
  logic ev_power;
  logic ev_tout;

  function automatic logic [13:0] rom_word(input logic [15:0] a);
    logic [13:0] w;
    w = 14'h0000;
    if (a >= `CCSIR_CFG_BASE && a <= `CCSIR_CFG_LAST) begin
      unique case (a[4:0])
        5'h00: w = `CCSIR_CFG_ERASE_ROW;
        5'h01: w = `CCSIR_CFG_LATCHES;
        5'h02: w = `CCSIR_CFG_USER_ROWS;
        5'h03: w = `CCSIR_CFG_EEPROM;
        `CCSIR_CFG_PINS_IDX: w = PIN_COUNT;
        default: w = 14'h0000;
      endcase
    end else if (a >= `CCSIR_INFO_BASE && a <= `CCSIR_INFO_LAST) begin
      w = INFO_FILL;
    end
    return w;
  endfunction

  // decodes whether a word index answers a read or a write
  function automatic logic idx_known(input logic [12:0] i, input logic wr);
    logic k;
    k = 1'b0;
    unique case (i)
      `CCSIR_IDX_STATUS, `CCSIR_IDX_WORKING_REGISTER, `CCSIR_IDX_BANK, `CCSIR_IDX_PCLATCH,
      `CCSIR_IDX_PTR0_LO, `CCSIR_IDX_PTR0_HI, `CCSIR_IDX_PTR1_LO, `CCSIR_IDX_PTR1_HI,
      `CCSIR_IDX_EVENT, `CCSIR_IDX_ROM_ADDR: k = 1'b1;
      `CCSIR_IDX_ROM_DATA: k = !wr;
      default: k = 1'b0;
    endcase
    return k;
  endfunction

  assign idx = i_paddr[`CCSIR_PADDR_MSB:`CCSIR_PADDR_LSB];
  assign wr_en = i_psel && i_penable && i_pwrite && !o_pready && !i_sys_rst;
  assign rd_en = i_psel && i_penable && !i_pwrite && !o_pready;
  // the event register is a write-only strobe word for core events
  assign ev_power = wr_en && idx == `CCSIR_IDX_EVENT && i_pwdata[`CCSIR_EV_POWERUP];
  assign ev_kick = wr_en && idx == `CCSIR_IDX_EVENT && i_pwdata[`CCSIR_EV_KICK];
  assign ev_sleep = wr_en && idx == `CCSIR_IDX_EVENT && i_pwdata[`CCSIR_EV_SLEEP];
  assign ev_tout = wr_en && idx == `CCSIR_IDX_EVENT && i_pwdata[`CCSIR_EV_TIMEOUT];

  // subtract runs as a + ~b + 1, so both carries see the added one
  always_comb begin
    cin = i_alu_op == ccsir_alu_sub;
    opnd_b = cin ? ~i_alu_b : i_alu_b;
    sum = {1'b0, i_alu_a} + {1'b0, opnd_b} + {8'h00, cin};
    nib_sum = {1'b0, i_alu_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
  end

  always_comb begin
    next_status = status_flags_shadow;
    next_working_register = working_reg_shadow;
    next_bank = bank_select_shadow;
    next_pcl = pc_upper_latch_shadow;
    next_ptr0 = indirect_pointer0_shadow;
    next_ptr1 = indirect_pointer1_shadow;
    next_rom_addr = rom_addr;
    if (wr_en) begin
      unique case (idx)
        `CCSIR_IDX_STATUS: next_status = (status_flags_shadow & ~`CCSIR_STATUS_RW_MASK) |
          (i_pwdata[7:0] & `CCSIR_STATUS_RW_MASK);
        `CCSIR_IDX_WORKING_REGISTER: next_working_register = i_pwdata[7:0];
        `CCSIR_IDX_BANK: next_bank = i_pwdata[7:0] & `CCSIR_BANK_MASK;
        `CCSIR_IDX_PCLATCH: next_pcl = i_pwdata[7:0] & `CCSIR_PCL_MASK;
        `CCSIR_IDX_PTR0_LO: next_ptr0[7:0] = i_pwdata[7:0];
        `CCSIR_IDX_PTR0_HI: next_ptr0[15:8] = i_pwdata[7:0];
        `CCSIR_IDX_PTR1_LO: next_ptr1[7:0] = i_pwdata[7:0];
        `CCSIR_IDX_PTR1_HI: next_ptr1[15:8] = i_pwdata[7:0];
        `CCSIR_IDX_ROM_ADDR: next_rom_addr = i_pwdata[15:0];
        default: ;
      endcase
    end
    // hardware updates win over a same-cycle software write
    if (i_alu_valid && i_alu_op != ccsir_alu_none) begin
      if (i_alu_op == ccsir_alu_logic) begin
        next_status[`CCSIR_BIT_ZERO] = (i_alu_a & i_alu_b) == 8'h00;
      end else begin
        next_status[`CCSIR_BIT_ZERO] = sum[7:0] == 8'h00;
        next_status[`CCSIR_BIT_NIB] = nib_sum[4];
        next_status[`CCSIR_BIT_MSB] = sum[8];
      end
    end
    if (i_rot_valid) begin
      next_status[`CCSIR_BIT_MSB] = i_rot_left ? i_rot_src[7] : i_rot_src[0];
    end
    if (ev_tout) begin
      next_status[`CCSIR_BIT_WDT] = 1'b0;
    end
    if (ev_sleep) begin
      next_status[`CCSIR_BIT_SLEEP] = 1'b0;
    end
    if (ev_power || ev_kick || ev_sleep) begin
      next_status[`CCSIR_BIT_WDT] = 1'b1;
    end
    if (ev_power || ev_kick) begin
      next_status[`CCSIR_BIT_SLEEP] = 1'b1;
    end
    next_status[7:5] = 3'h0;
    next_bank[7:6] = 2'h0;
    next_pcl[7] = 1'b0;
  end

  // shadows have no reset term, so a reset leaves them as they were
  always_ff @(posedge i_clk_sys) begin
    status_flags_shadow <= next_status;
    working_reg_shadow <= next_working_register;
    bank_select_shadow <= next_bank;
    pc_upper_latch_shadow <= next_pcl;
    indirect_pointer0_shadow <= next_ptr0;
    indirect_pointer1_shadow <= next_ptr1;
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = (rd_en || wr_en) && !idx_known(idx, i_pwrite);
    next_pready = i_psel && i_penable && !o_pready;
    if (rd_en) begin
      unique case (idx)
        `CCSIR_IDX_STATUS: next_prdata[7:0] = status_flags_shadow;
        `CCSIR_IDX_WORKING_REGISTER: next_prdata[7:0] = working_reg_shadow;
        `CCSIR_IDX_BANK: next_prdata[7:0] = bank_select_shadow;
        `CCSIR_IDX_PCLATCH: next_prdata[7:0] = pc_upper_latch_shadow;
        `CCSIR_IDX_PTR0_LO: next_prdata[7:0] = indirect_pointer0_shadow[7:0];
        `CCSIR_IDX_PTR0_HI: next_prdata[7:0] = indirect_pointer0_shadow[15:8];
        `CCSIR_IDX_PTR1_LO: next_prdata[7:0] = indirect_pointer1_shadow[7:0];
        `CCSIR_IDX_PTR1_HI: next_prdata[7:0] = indirect_pointer1_shadow[15:8];
        `CCSIR_IDX_ROM_ADDR: next_prdata[15:0] = rom_addr;
        `CCSIR_IDX_ROM_DATA: next_prdata[13:0] = rom_word(rom_addr);
        `CCSIR_IDX_EVENT: next_prdata = 32'h0000_0000;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      rom_addr <= 16'h0000;
      o_status_flags_shadow <= 8'h00;
    end else begin
      o_prdata <= next_prdata;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
      rom_addr <= next_rom_addr;
      o_status_flags_shadow <= next_status;
    end
  end

  // checks
  property p_msb_add;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_alu_valid && i_alu_op == ccsir_alu_add && !i_rot_valid) |=>
      status_flags_shadow[`CCSIR_BIT_MSB] == ($past({1'b0, i_alu_a}) + $past({1'b0, i_alu_b})) >> 8;
  endproperty
  a_msb_add: assert property (p_msb_add) else $error("msb flag wrong after add");
  property p_nib_add;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_alu_valid && i_alu_op == ccsir_alu_add) |=>
      status_flags_shadow[`CCSIR_BIT_NIB] == (($past(i_alu_a[3:0]) + $past(i_alu_b[3:0])) > 15);
  endproperty
  a_nib_add: assert property (p_nib_add) else $error("nibble flag wrong after add");
  property p_sub_borrow;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_alu_valid && i_alu_op == ccsir_alu_sub && !i_rot_valid) |=>
      status_flags_shadow[`CCSIR_BIT_MSB] == ($past(i_alu_a) >= $past(i_alu_b));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");
  property p_zero;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_alu_valid && i_alu_op == ccsir_alu_add) |=>
      status_flags_shadow[`CCSIR_BIT_ZERO] == ($past(8'(i_alu_a + i_alu_b)) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_rot;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_rot_valid && i_rot_left |=> status_flags_shadow[`CCSIR_BIT_MSB] == $past(i_rot_src[7]);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate did not load msb flag");
  property p_tout;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    ev_tout && !ev_power && !ev_kick && !ev_sleep |=> !status_flags_shadow[`CCSIR_BIT_WDT];
  endproperty
  a_tout: assert property (p_tout) else $error("timeout did not clear expiry flag");
  property p_sleep;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    ev_sleep && !ev_power && !ev_kick |=>
      !status_flags_shadow[`CCSIR_BIT_SLEEP] && status_flags_shadow[`CCSIR_BIT_WDT];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_upper_zero;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    ##1 status_flags_shadow[7:5] == 3'h0 && bank_select_shadow[7:6] == 2'h0 &&
      pc_upper_latch_shadow[7] == 1'b0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("absent bits not zero");
  property p_ro_bits;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_en && idx == `CCSIR_IDX_STATUS |=> $stable(status_flags_shadow[4:3]);
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("read-only status bits changed");
  property p_ready_one;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready not a single cycle");
  property p_nib_sub;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_alu_valid && i_alu_op == ccsir_alu_sub) |=>
      status_flags_shadow[`CCSIR_BIT_NIB] == ($past(i_alu_a[3:0]) >= $past(i_alu_b[3:0]));
  endproperty
  a_nib_sub: assert property (p_nib_sub) else $error("nibble borrow wrong after sub");
  property p_zero_sub;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_alu_valid && i_alu_op == ccsir_alu_sub) |=>
      status_flags_shadow[`CCSIR_BIT_ZERO] == ($past(i_alu_a) == $past(i_alu_b));
  endproperty
  a_zero_sub: assert property (p_zero_sub) else $error("zero flag wrong after sub");
  property p_zero_logic;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_alu_valid && i_alu_op == ccsir_alu_logic) |=>
      status_flags_shadow[`CCSIR_BIT_ZERO] == (($past(i_alu_a) & $past(i_alu_b)) == 8'h00);
  endproperty
  a_zero_logic: assert property (p_zero_logic) else $error("zero flag wrong after logic");
  property p_rot_right;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_rot_valid && !i_rot_left |=>
      status_flags_shadow[`CCSIR_BIT_MSB] == $past(i_rot_src[0]);
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("right rotate msb flag wrong");
  property p_wake;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    ev_power || ev_kick |=>
      status_flags_shadow[`CCSIR_BIT_WDT] && status_flags_shadow[`CCSIR_BIT_SLEEP];
  endproperty
  a_wake: assert property (p_wake) else $error("power-up or kick left a flag clear");
  property p_err_read;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    rd_en && !idx_known(idx, 1'b0) |=> o_pready && o_pslverr && o_prdata == 32'h0000_0000;
  endproperty
  a_err_read: assert property (p_err_read) else $error("reserved read not refused");
  property p_err_write;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_en && !idx_known(idx, 1'b1) |=> o_pready && o_pslverr;
  endproperty
  a_err_write: assert property (p_err_write) else $error("read-only write not refused");
  property p_working_register_read;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    rd_en && idx == `CCSIR_IDX_WORKING_REGISTER |=> o_prdata == {24'h000000, $past(working_reg_shadow)};
  endproperty
  a_working_register_read: assert property (p_working_register_read) else $error("working shadow read wrong");
  property p_bank_write;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_en && idx == `CCSIR_IDX_BANK |=>
      bank_select_shadow == ($past(i_pwdata[7:0]) & `CCSIR_BANK_MASK);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank shadow write wrong");
  property p_pcl_write;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_en && idx == `CCSIR_IDX_PCLATCH |=>
      pc_upper_latch_shadow == ($past(i_pwdata[7:0]) & `CCSIR_PCL_MASK);
  endproperty
  a_pcl_write: assert property (p_pcl_write) else $error("pc latch shadow write wrong");
  property p_ptr_bytes;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_en && idx == `CCSIR_IDX_PTR0_HI |=>
      indirect_pointer0_shadow[7:0] == $past(indirect_pointer0_shadow[7:0]);
  endproperty
  a_ptr_bytes: assert property (p_ptr_bytes) else $error("high byte write hit low byte");
  property p_status_write;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_en && idx == `CCSIR_IDX_STATUS && !i_alu_valid && !i_rot_valid |=>
      status_flags_shadow[2:0] == $past(i_pwdata[2:0]);
  endproperty
  a_status_write: assert property (p_status_write) else $error("status write lost");
  property p_rom_cfg;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    rd_en && idx == `CCSIR_IDX_ROM_DATA && rom_addr == `CCSIR_CFG_BASE |=>
      o_prdata == {18'h00000, `CCSIR_CFG_ERASE_ROW};
  endproperty
  a_rom_cfg: assert property (p_rom_cfg) else $error("erase row word wrong");
  c_add: cover property (@(posedge i_clk_sys) i_alu_valid && i_alu_op == ccsir_alu_add);
  c_sub: cover property (@(posedge i_clk_sys) i_alu_valid && i_alu_op == ccsir_alu_sub);
  c_event: cover property (@(posedge i_clk_sys) ev_sleep && ev_tout);
  c_rom: cover property (@(posedge i_clk_sys) rd_en && idx == `CCSIR_IDX_ROM_DATA);
  c_ptr: cover property (@(posedge i_clk_sys) wr_en && idx == `CCSIR_IDX_PTR1_HI);
endmodule

// ==== sim/core_context_shadow_and_info_rom_tb.sv ====
// self-checking bench for the context shadow bank and its information tables
// assumes the design answers apb requests with pready and drives the status copy port
`timescale 1ns/10ps
`include "ccsir_regs.svh"
module core_context_shadow_and_info_rom_tb
  import ccsir_pkg::*;
;
  typedef struct packed {logic [12:0] idx; logic [31:0] wd; logic [31:0] exp;} ccsir_reg_row_s;
  typedef struct packed {
    logic [1:0] kind;
    ccsir_alu_e op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] mask;
    logic [7:0] exp;
  } ccsir_op_row_s;
  typedef struct packed {logic [15:0] addr; logic [13:0] exp;} ccsir_rom_row_s;
  localparam logic [13:0] PINS = 14'h0010;
  localparam logic [13:0] FILL = 14'h2A5C;
  localparam ccsir_reg_row_s REG_ROWS [7] = '{
    '{`CCSIR_IDX_WORKING_REGISTER, 32'hFFFFFFA5, 32'h000000A5},
    '{`CCSIR_IDX_BANK, 32'hFFFFFFEA, 32'h0000002A},
    '{`CCSIR_IDX_PCLATCH, 32'hFFFFFFD5, 32'h00000055},
    '{`CCSIR_IDX_PTR0_LO, 32'hFFFFFF12, 32'h00000012},
    '{`CCSIR_IDX_PTR0_HI, 32'hFFFFFF34, 32'h00000034},
    '{`CCSIR_IDX_PTR1_LO, 32'hFFFFFF56, 32'h00000056},
    '{`CCSIR_IDX_PTR1_HI, 32'hFFFFFF78, 32'h00000078}};
  localparam ccsir_op_row_s OP_ROWS [14] = '{
    '{2'h0, ccsir_alu_add, 8'h0F, 8'h01, 8'h07, 8'h02},
    '{2'h0, ccsir_alu_add, 8'hFF, 8'h01, 8'h07, 8'h07},
    '{2'h0, ccsir_alu_add, 8'h80, 8'h80, 8'h07, 8'h05},
    '{2'h0, ccsir_alu_sub, 8'h05, 8'h05, 8'h07, 8'h07},
    '{2'h0, ccsir_alu_sub, 8'h03, 8'h05, 8'h07, 8'h00},
    '{2'h0, ccsir_alu_sub, 8'h07, 8'h00, 8'h07, 8'h03},
    '{2'h0, ccsir_alu_sub, 8'h25, 8'h10, 8'h07, 8'h03},
    '{2'h0, ccsir_alu_sub, 8'h10, 8'h01, 8'h07, 8'h01},
    '{2'h0, ccsir_alu_logic, 8'hF0, 8'h0F, 8'h04, 8'h04},
    '{2'h0, ccsir_alu_logic, 8'hFF, 8'h01, 8'h04, 8'h00},
    '{2'h1, ccsir_alu_none, 8'h80, 8'h00, 8'h01, 8'h01},
    '{2'h2, ccsir_alu_none, 8'hFE, 8'h00, 8'h01, 8'h00},
    '{2'h1, ccsir_alu_none, 8'h7F, 8'h00, 8'h01, 8'h00},
    '{2'h2, ccsir_alu_none, 8'h01, 8'h00, 8'h01, 8'h01}};
  localparam ccsir_rom_row_s ROM_ROWS [9] = '{
    '{16'h8200, 14'h0020}, '{16'h8201, 14'h0020}, '{16'h8202, 14'h0200},
    '{16'h8203, 14'h0100}, '{16'h8204, PINS}, '{16'h8205, 14'h0000},
    '{16'h821F, 14'h0000}, '{16'h8100, FILL}, '{16'h811F, FILL}};
  localparam logic [7:0] EV_ROWS [8][2] = '{
    '{8'h01, 8'h18}, '{8'h04, 8'h10}, '{8'h08, 8'h00}, '{8'h02, 8'h18},
    '{8'h04, 8'h10}, '{8'h0C, 8'h10}, '{8'h0A, 8'h18}, '{8'h01, 8'h18}};
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [14:0] i_paddr = 15'h0000;
  logic [31:0] i_pwdata = 32'h00000000;
  logic i_alu_valid = 1'b0;
  ccsir_alu_e i_alu_op = ccsir_alu_none;
  logic [7:0] i_alu_a = 8'h00;
  logic [7:0] i_alu_b = 8'h00;
  logic i_rot_valid = 1'b0;
  logic i_rot_left = 1'b0;
  logic [7:0] i_rot_src = 8'h00;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic [7:0] o_status_flags_shadow;
  logic [31:0] rd;
  logic err;
  logic [7:0] m;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  ccsir_shadow_bank #(.ADDR_W(15), .PIN_COUNT(PINS), .INFO_FILL(FILL)) i_dut (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_alu_valid(i_alu_valid),
    .i_alu_op(i_alu_op), .i_alu_a(i_alu_a), .i_alu_b(i_alu_b), .i_rot_valid(i_rot_valid),
    .i_rot_left(i_rot_left), .i_rot_src(i_rot_src),
    .o_status_flags_shadow(o_status_flags_shadow));

  initial begin
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic print_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [12:0] idx, input logic [31:0] wd);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= {idx, 2'b00};
    i_pwdata <= wd;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [12:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    chk(nm, exp, rd);
  endtask

  task automatic pulse(input ccsir_op_row_s r);
    @(posedge i_clk_sys);
    i_alu_valid <= (r.kind == 2'h0);
    i_rot_valid <= (r.kind != 2'h0);
    i_alu_op <= r.op;
    i_alu_a <= r.a;
    i_alu_b <= r.b;
    i_rot_left <= (r.kind == 2'h1);
    i_rot_src <= r.a;
    @(posedge i_clk_sys);
    i_alu_valid <= 1'b0;
    i_rot_valid <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge i_clk_sys);
    chk("pready in reset", 32'(o_pready), 32'h0);
    chk("status port in reset", 32'(o_status_flags_shadow), 32'h0);
    i_sys_rst <= 1'b0;
    foreach (REG_ROWS[k]) apb(1'b1, REG_ROWS[k].idx, REG_ROWS[k].wd);
    foreach (REG_ROWS[k]) rchk("shadow reg", REG_ROWS[k].idx, REG_ROWS[k].exp);
    $display("test shadow registers done");
    apb(1'b1, `CCSIR_IDX_EVENT, 32'h00000001);
    apb(1'b1, `CCSIR_IDX_STATUS, 32'hFFFFFFFF);
    rchk("status all ones", `CCSIR_IDX_STATUS, 32'h0000001F);
    apb(1'b1, `CCSIR_IDX_STATUS, 32'h00000000);
    rchk("status ro bits", `CCSIR_IDX_STATUS, 32'h00000018);
    foreach (EV_ROWS[k]) begin
      apb(1'b1, `CCSIR_IDX_EVENT, 32'(EV_ROWS[k][0]));
      apb(1'b0, `CCSIR_IDX_STATUS, 32'h0);
      chk("status after event", 32'(EV_ROWS[k][1]), rd & 32'h000000F8);
    end
    $display("test status events done");
    foreach (OP_ROWS[k]) begin
      pulse(OP_ROWS[k]);
      apb(1'b0, `CCSIR_IDX_STATUS, 32'h0);
      m = OP_ROWS[k].mask | 8'hF8;
      chk("status after op", 32'(OP_ROWS[k].exp | 8'h18), rd & {24'hFFFFFF, m});
      chk("status port", 32'(OP_ROWS[k].exp | 8'h18), 32'(o_status_flags_shadow & m));
    end
    $display("test flag logic done");
    foreach (ROM_ROWS[k]) begin
      apb(1'b1, `CCSIR_IDX_ROM_ADDR, 32'(ROM_ROWS[k].addr));
      rchk("table word", `CCSIR_IDX_ROM_DATA, 32'(ROM_ROWS[k].exp));
    end
    apb(1'b1, `CCSIR_IDX_ROM_ADDR, 32'h00008200);
    apb(1'b1, `CCSIR_IDX_ROM_DATA, 32'h00000000);
    chk("table write err", 32'(err), 32'h1);
    rchk("table after write", `CCSIR_IDX_ROM_DATA, 32'h00000020);
    rchk("table address", `CCSIR_IDX_ROM_ADDR, 32'h00008200);
    $display("test tables done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, k ? 13'h1FE3 : 13'h0000, 32'hFFFFFFFF);
      chk("reserved write err", 32'(err), 32'h1);
      rchk("reserved read", k ? 13'h1FE3 : 13'h0000, 32'h0);
      chk("reserved read err", 32'(err), 32'h1);
    end
    $display("test reserved done");
    apb(1'b1, `CCSIR_IDX_WORKING_REGISTER, 32'h0000005A);
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rchk("working_register over reset", `CCSIR_IDX_WORKING_REGISTER, 32'h0000005A);
    rchk("ptr1 hi over reset", `CCSIR_IDX_PTR1_HI, 32'h00000078);
    rchk("status over reset", `CCSIR_IDX_STATUS, 32'h00000019);
    $display("test reset retention done");
    print_verdict();
  end
endmodule
